// [pkg/scfg_cfg.svh]
// Register indexes, field positions, codes and reset values of the serial port setup bank.
`ifndef SCFG_CFG_SVH
`define SCFG_CFG_SVH
`define SCFG_IDX_PROTO 6'h02
`define SCFG_IDX_BUFADDR 6'h05
`define SCFG_IDX_CHARTMO 6'h06
`define SCFG_IDX_HSHAKE 6'h07
`define SCFG_IDX_RSTTMO 6'h24
`define SCFG_RST_RSTTMO 16'h3030
`define SCFG_PROTO_MSB 7
`define SCFG_PROTO_LSB 4
`define SCFG_PROTO_RAW 4'h1
`define SCFG_PROTO_RTU 4'h2
`define SCFG_PROTO_P4 4'h4
`define SCFG_PROTO_P8 4'h8
`define SCFG_PROTO_AUTO 4'he
`define SCFG_REQ_STD 16'h0055
`define SCFG_REQ_LO 8'h55
`define SCFG_REQ_RAW_TOP 6'h1c
`define SCFG_ACK_LO 8'haa
`define SCFG_ERR_NIB 4'he
`define SCFG_HI_STD 8'h00
`define SCFG_HI_RAW 8'h70
`define SCFG_XON_BIT 8
`define SCFG_RTS_BIT 9
`define SCFG_BUF_LAST_OFS 16'h003f
`define SCFG_BUF_MAX_BASE 16'hffc0
`endif

// [pkg/scfg_pkg.sv]
// Types shared by the serial port setup bank.
package scfg_pkg;
   typedef enum logic {scfg_idle, scfg_check} scfg_state_e;
   typedef logic [15:0] scfg_word_t;
endpackage : scfg_pkg

// [hdl/scfg_bank.sv]
// Serial port setup bank with request and completion handshake, reached over Wishbone.
`timescale 1ns/1ps
`include "scfg_cfg.svh"
module scfg_bank
   import scfg_pkg::*;
(
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic wb_we_i,
   input wire logic [7:0] wb_adr_i,
   input wire logic [3:0] wb_sel_i,
   input wire logic [31:0] wb_dat_i,
   output logic [31:0] wb_dat_o,
   output logic wb_ack_o,
   output logic raw_ascii_o,
   output logic [3:0] proto_sel_o,
   output logic xon_en_o,
   output logic rts_en_o,
   output logic [15:0] buf_base_o,
   output logic [15:0] buf_last_o,
   output logic char_tmo_35_o,
   output logic [13:0] char_tmo_ms_o,
   output logic [6:0] p1_tmo_s_o,
   output logic [6:0] p2_tmo_s_o,
   output logic p1_tmo_en_o,
   output logic p2_tmo_en_o
);

   // True when every nibble of the word is a decimal digit.
   function automatic logic bcd_ok(input scfg_word_t w);
      bcd_ok = (w[3:0] < 4'ha) && (w[7:4] < 4'ha) && (w[11:8] < 4'ha) && (w[15:12] < 4'ha);
   endfunction : bcd_ok

   // Converts four BCD digits to binary.
   function automatic logic [13:0] bcd_to_bin(input scfg_word_t w);
      logic [13:0] acc;
      acc = 14'(w[15:12]) * 14'd1000;
      acc = acc + 14'(w[11:8]) * 14'd100;
      acc = acc + 14'(w[7:4]) * 14'd10;
      bcd_to_bin = acc + 14'(w[3:0]);
   endfunction : bcd_to_bin

   logic [5:0] idx;
   logic bus_req, bus_wr, next_ack;
   logic [31:0] next_dat;

   scfg_word_t proto_w, bufaddr_w, chartmo_w, hshake_w, rsttmo_w;
   scfg_state_e state;

   scfg_word_t next_proto_w, next_bufaddr_w, next_chartmo_w, next_hshake_w, next_rsttmo_w;
   scfg_state_e next_state;
   logic next_raw, next_xon, next_rts, next_char35, next_p1_en, next_p2_en;
   logic [3:0] next_proto_sel;
   logic [15:0] next_buf_base, next_buf_last;
   logic [13:0] next_char_ms;
   logic [6:0] next_p1_s, next_p2_s;

   logic [3:0] req_proto;
   logic req_raw, std_req, raw_req, param_ok;
   logic [3:0] err_idx;
   logic [13:0] tmo1_bin, tmo2_bin;

   assign idx = wb_adr_i[7:2];
   assign bus_req = wb_cyc_i && wb_stb_i;
   // A write takes effect on the edge where the master sees ack.
   assign bus_wr = bus_req && wb_we_i && wb_ack_o;

   // Merges a bus write into a 16-bit word under the byte selects.
   function automatic scfg_word_t merge(input scfg_word_t old, input logic [3:0] sel,
                                        input logic [31:0] dat);
      merge = {sel[1] ? dat[15:8] : old[15:8], sel[0] ? dat[7:0] : old[7:0]};
   endfunction : merge

   always_comb
   begin
      next_ack = bus_req && !wb_ack_o;
      next_dat = wb_dat_o;
      if (bus_req && !wb_ack_o)
      begin
         unique case (idx)
            `SCFG_IDX_PROTO: next_dat = {16'h0000, proto_w};
            `SCFG_IDX_BUFADDR: next_dat = {16'h0000, bufaddr_w};
            `SCFG_IDX_CHARTMO: next_dat = {16'h0000, chartmo_w};
            `SCFG_IDX_HSHAKE: next_dat = {16'h0000, hshake_w};
            `SCFG_IDX_RSTTMO: next_dat = {16'h0000, rsttmo_w};
            default: next_dat = 32'h0000_0000;
         endcase
      end
   end

   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         wb_ack_o <= 1'b0;
         wb_dat_o <= 32'h0000_0000;
      end
      else
      begin
         wb_ack_o <= next_ack;
         wb_dat_o <= next_dat;
      end
   end

   // Parameter check, lowest faulty word offset first.
   always_comb
   begin
      req_proto = proto_w[`SCFG_PROTO_MSB:`SCFG_PROTO_LSB];
      req_raw = (req_proto == `SCFG_PROTO_RAW);
      std_req = (hshake_w == `SCFG_REQ_STD) && !req_raw;
      raw_req = (hshake_w[15:10] == `SCFG_REQ_RAW_TOP) && (hshake_w[7:0] == `SCFG_REQ_LO)
                && req_raw;
      err_idx = 4'h0;
      if (!(req_proto inside {`SCFG_PROTO_RAW, `SCFG_PROTO_RTU, `SCFG_PROTO_P4,
                              `SCFG_PROTO_P8, `SCFG_PROTO_AUTO}))
      begin
         err_idx = 4'(`SCFG_IDX_PROTO);
      end
      else if (req_raw && (bufaddr_w > `SCFG_BUF_MAX_BASE))
      begin
         err_idx = 4'(`SCFG_IDX_BUFADDR);
      end
      else if (!bcd_ok(chartmo_w))
      begin
         err_idx = 4'(`SCFG_IDX_CHARTMO);
      end
      else if (!bcd_ok(rsttmo_w))
      begin
         err_idx = 4'(`SCFG_IDX_RSTTMO);
      end
      param_ok = (err_idx == 4'h0);
      tmo1_bin = bcd_to_bin({8'h00, rsttmo_w[7:0]});
      tmo2_bin = bcd_to_bin({8'h00, rsttmo_w[15:8]});
   end

   always_comb
   begin
      next_proto_w = proto_w;
      next_bufaddr_w = bufaddr_w;
      next_chartmo_w = chartmo_w;
      next_hshake_w = hshake_w;
      next_rsttmo_w = rsttmo_w;
      next_state = state;
      next_raw = raw_ascii_o;
      next_proto_sel = proto_sel_o;
      next_xon = xon_en_o;
      next_rts = rts_en_o;
      next_buf_base = buf_base_o;
      next_buf_last = buf_last_o;
      next_char35 = char_tmo_35_o;
      next_char_ms = char_tmo_ms_o;
      next_p1_s = p1_tmo_s_o;
      next_p2_s = p2_tmo_s_o;
      next_p1_en = p1_tmo_en_o;
      next_p2_en = p2_tmo_en_o;
      if (bus_wr)
      begin
         unique case (idx)
            `SCFG_IDX_PROTO: next_proto_w = merge(proto_w, wb_sel_i, wb_dat_i);
            `SCFG_IDX_BUFADDR: next_bufaddr_w = merge(bufaddr_w, wb_sel_i, wb_dat_i);
            `SCFG_IDX_CHARTMO: next_chartmo_w = merge(chartmo_w, wb_sel_i, wb_dat_i);
            `SCFG_IDX_HSHAKE: next_hshake_w = merge(hshake_w, wb_sel_i, wb_dat_i);
            `SCFG_IDX_RSTTMO: next_rsttmo_w = merge(rsttmo_w, wb_sel_i, wb_dat_i);
            default: next_state = state;
         endcase
      end
      unique case (state)
         scfg_idle:
         begin
            if (bus_wr && (idx == `SCFG_IDX_HSHAKE))
            begin
               next_state = scfg_check;
            end
         end
         scfg_check:
         begin
            next_state = scfg_idle;
            if ((std_req || raw_req) && !param_ok)
            begin
               // Active parameters are left untouched on a failed check.
               next_hshake_w = {raw_req ? `SCFG_HI_RAW : `SCFG_HI_STD, `SCFG_ERR_NIB,
                                err_idx};
            end
            else if (std_req || raw_req)
            begin
               next_hshake_w = {hshake_w[15:8], `SCFG_ACK_LO};
               next_raw = req_raw;
               next_proto_sel = req_proto;
               next_xon = raw_req && hshake_w[`SCFG_XON_BIT];
               next_rts = raw_req && hshake_w[`SCFG_RTS_BIT];
               next_buf_base = bufaddr_w;
               next_buf_last = bufaddr_w + `SCFG_BUF_LAST_OFS;
               next_char35 = (chartmo_w == 16'h0000) && (req_proto == `SCFG_PROTO_RTU);
               next_char_ms = bcd_to_bin(chartmo_w);
               next_p1_s = tmo1_bin[6:0];
               next_p2_s = tmo2_bin[6:0];
               next_p1_en = (rsttmo_w[7:0] != 8'h00);
               next_p2_en = (rsttmo_w[15:8] != 8'h00);
            end
         end
      endcase
   end

   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         proto_w <= 16'h0000;
         bufaddr_w <= 16'h0000;
         chartmo_w <= 16'h0000;
         hshake_w <= 16'h0000;
         rsttmo_w <= `SCFG_RST_RSTTMO;
         state <= scfg_idle;
         raw_ascii_o <= 1'b0;
         proto_sel_o <= 4'h0;
         xon_en_o <= 1'b0;
         rts_en_o <= 1'b0;
         buf_base_o <= 16'h0000;
         buf_last_o <= `SCFG_BUF_LAST_OFS;
         char_tmo_35_o <= 1'b0;
         char_tmo_ms_o <= 14'h0000;
         p1_tmo_s_o <= 7'h1e;
         p2_tmo_s_o <= 7'h1e;
         p1_tmo_en_o <= 1'b1;
         p2_tmo_en_o <= 1'b1;
      end
      else
      begin
         proto_w <= next_proto_w;
         bufaddr_w <= next_bufaddr_w;
         chartmo_w <= next_chartmo_w;
         hshake_w <= next_hshake_w;
         rsttmo_w <= next_rsttmo_w;
         state <= next_state;
         raw_ascii_o <= next_raw;
         proto_sel_o <= next_proto_sel;
         xon_en_o <= next_xon;
         rts_en_o <= next_rts;
         buf_base_o <= next_buf_base;
         buf_last_o <= next_buf_last;
         char_tmo_35_o <= next_char35;
         char_tmo_ms_o <= next_char_ms;
         p1_tmo_s_o <= next_p1_s;
         p2_tmo_s_o <= next_p2_s;
         p1_tmo_en_o <= next_p1_en;
         p2_tmo_en_o <= next_p2_en;
      end
   end

   property p_std_ok;
      @(posedge clk_i) disable iff (rst_i)
      (state == scfg_check) && std_req && param_ok |=> (hshake_w == 16'h00aa);
   endproperty
   a_std_ok: assert property (p_std_ok) else $error("standard request not acknowledged");

   property p_std_err;
      @(posedge clk_i) disable iff (rst_i)
      (state == scfg_check) && std_req && !param_ok
      |=> (hshake_w[15:4] == 12'h00e) && (hshake_w[3:0] == $past(err_idx));
   endproperty
   a_std_err: assert property (p_std_err) else $error("standard error code wrong");

   property p_raw_ok;
      @(posedge clk_i) disable iff (rst_i)
      (state == scfg_check) && raw_req && param_ok
      |=> (hshake_w[7:0] == 8'haa) && (hshake_w[15:8] == $past(hshake_w[15:8]));
   endproperty
   a_raw_ok: assert property (p_raw_ok) else $error("raw request not acknowledged");

   property p_raw_err;
      @(posedge clk_i) disable iff (rst_i)
      (state == scfg_check) && raw_req && !param_ok |=> (hshake_w[15:4] == 12'h70e);
   endproperty
   a_raw_err: assert property (p_raw_err) else $error("raw error code wrong");

   property p_flow_set;
      @(posedge clk_i) disable iff (rst_i)
      (state == scfg_check) && raw_req && param_ok
      |=> (xon_en_o == $past(hshake_w[8])) && (rts_en_o == $past(hshake_w[9]));
   endproperty
   a_flow_set: assert property (p_flow_set) else $error("flow enables wrong");

   property p_flow_raw;
      @(posedge clk_i) disable iff (rst_i)
      (xon_en_o || rts_en_o) |-> raw_ascii_o;
   endproperty
   a_flow_raw: assert property (p_flow_raw) else $error("flow control outside raw mode");

   property p_keep;
      @(posedge clk_i) disable iff (rst_i)
      (state == scfg_check) && !(param_ok && (std_req || raw_req))
      |=> $stable(buf_base_o) && $stable(char_tmo_ms_o) && $stable(raw_ascii_o);
   endproperty
   a_keep: assert property (p_keep) else $error("parameters changed without valid request");

   property p_buf;
      @(posedge clk_i) disable iff (rst_i)
      raw_ascii_o |-> (buf_last_o == buf_base_o + 16'h003f);
   endproperty
   a_buf: assert property (p_buf) else $error("buffer area not 64 words");

   property p_char35;
      @(posedge clk_i) disable iff (rst_i)
      char_tmo_35_o |-> (char_tmo_ms_o == 14'h0000) && (proto_sel_o == 4'h2);
   endproperty
   a_char35: assert property (p_char35) else $error("3.5 character mode misapplied");

   property p_tmo_en;
      @(posedge clk_i) disable iff (rst_i)
      (p1_tmo_en_o == (p1_tmo_s_o != 7'h00)) && (p2_tmo_en_o == (p2_tmo_s_o != 7'h00));
   endproperty
   a_tmo_en: assert property (p_tmo_en) else $error("timeout enable mismatch");

   property p_ack;
      @(posedge clk_i) disable iff (rst_i)
      bus_req && !wb_ack_o |=> wb_ack_o ##1 !wb_ack_o;
   endproperty
   a_ack: assert property (p_ack) else $error("bus ack timing wrong");
endmodule : scfg_bank

// [testbench/scfg_bank_tb.sv]
// Self-checking bench for the serial port setup bank, driven over classic Wishbone.
`timescale 1ns/1ps
`define CHK(nm, e, g) \
begin \
   checks++; \
   if ((g) !== (e)) \
   begin \
      miscompares++; \
      $display("wrong value %s expected %h seen %h", nm, e, g); \
   end \
end
module testbench;
   logic clk_i = 1'b0;
   logic rst_i = 1'b1;
   logic wb_cyc_i = 1'b0;
   logic wb_stb_i = 1'b0;
   logic wb_we_i = 1'b0;
   logic [7:0] wb_adr_i = 8'h00;
   logic [3:0] wb_sel_i = 4'h0;
   logic [31:0] wb_dat_i = 32'h00000000;
   logic [31:0] wb_dat_o;
   logic wb_ack_o, raw_ascii_o, xon_en_o, rts_en_o, char_tmo_35_o;
   logic p1_tmo_en_o, p2_tmo_en_o;
   logic [3:0] proto_sel_o;
   logic [15:0] buf_base_o, buf_last_o, rd;
   logic [13:0] char_tmo_ms_o;
   logic [6:0] p1_tmo_s_o, p2_tmo_s_o;
   logic [3:0] k;
   int miscompares = 0;
   int checks = 0;

   always #2.5 clk_i = ~clk_i;

   scfg_bank u_scfg_bank (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i),
      .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i),
      .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
      .raw_ascii_o(raw_ascii_o), .proto_sel_o(proto_sel_o), .xon_en_o(xon_en_o),
      .rts_en_o(rts_en_o), .buf_base_o(buf_base_o), .buf_last_o(buf_last_o),
      .char_tmo_35_o(char_tmo_35_o), .char_tmo_ms_o(char_tmo_ms_o),
      .p1_tmo_s_o(p1_tmo_s_o), .p2_tmo_s_o(p2_tmo_s_o), .p1_tmo_en_o(p1_tmo_en_o),
      .p2_tmo_en_o(p2_tmo_en_o));

   task automatic give_verdict();
      if (miscompares == 0 && checks > 0)
         $display("STATUS OK");
      else
         $display("STATUS NOT OK");
      $finish;
   endtask : give_verdict

   // Holds the request until ack is sampled high, then releases it at that same edge.
   task automatic wb_xfer(input logic we, input logic [7:0] adr, input logic [15:0] wd,
      output logic [15:0] rdat);
      @(posedge clk_i);
      wb_cyc_i <= 1'b1;
      wb_stb_i <= 1'b1;
      wb_we_i <= we;
      wb_adr_i <= adr;
      wb_sel_i <= 4'h3;
      wb_dat_i <= {16'h0000, wd};
      do @(posedge clk_i); while (wb_ack_o !== 1'b1);
      rdat = wb_dat_o[15:0];
      wb_cyc_i <= 1'b0;
      wb_stb_i <= 1'b0;
      wb_we_i <= 1'b0;
   endtask : wb_xfer

   task automatic wr(input logic [7:0] adr, input logic [15:0] wd);
      logic [15:0] dummy;
      wb_xfer(1'b1, adr, wd, dummy);
   endtask : wr

   task automatic rd_chk(input logic [7:0] adr, input logic [15:0] exp, input string nm);
      wb_xfer(1'b0, adr, 16'h0000, rd);
      `CHK(nm, exp, rd)
   endtask : rd_chk

   task automatic req(input logic [15:0] code, input logic [15:0] exp);
      wr(8'h1c, code);
      repeat (2) @(posedge clk_i);
      rd_chk(8'h1c, exp, "handshake");
   endtask : req

   initial
   begin
      repeat (2) @(posedge clk_i);
      rst_i <= 1'b0;
      rd_chk(8'h90, 16'h3030, "reset_timeout_word");
      `CHK("p1_seconds", 7'h1e, p1_tmo_s_o)
      `CHK("p2_enable", 1'b1, p2_tmo_en_o)
      `CHK("buf_last_init", 16'h003f, buf_last_o)
      rd_chk(8'hfc, 16'h0000, "unmapped");
      wr(8'h08, 16'h0020);
      wr(8'h18, 16'h0000);
      req(16'h0055, 16'h00aa);
      `CHK("proto_sel", 4'h2, proto_sel_o)
      `CHK("raw_ascii", 1'b0, raw_ascii_o)
      `CHK("char_35", 1'b1, char_tmo_35_o)
      `CHK("xon_off_mode", 1'b0, xon_en_o)
      wr(8'h18, 16'h1234);
      wr(8'h90, 16'h0599);
      req(16'h0055, 16'h00aa);
      `CHK("char_ms", 14'h04d2, char_tmo_ms_o)
      `CHK("p1_seconds", 7'h63, p1_tmo_s_o)
      `CHK("p2_seconds", 7'h05, p2_tmo_s_o)
      wr(8'h90, 16'h0500);
      req(16'h0055, 16'h00aa);
      `CHK("p1_enable", 1'b0, p1_tmo_en_o)
      `CHK("p2_enable", 1'b1, p2_tmo_en_o)
      wr(8'h18, 16'h12a4);
      req(16'h0055, 16'h00e6);
      `CHK("char_ms_kept", 14'h04d2, char_tmo_ms_o)
      wr(8'h18, 16'h0000);
      wr(8'h08, 16'h0030);
      req(16'h0055, 16'h00e2);
      `CHK("proto_kept", 4'h2, proto_sel_o)
      wr(8'h08, 16'h0010);
      wr(8'h14, 16'h1000);
      for (k = 4'h0; k < 4'h4; k++)
      begin
         req({4'h7, k, 8'h55}, {4'h7, k, 8'haa});
         `CHK("xon_en", k[0], xon_en_o)
         `CHK("rts_en", k[1], rts_en_o)
      end
      `CHK("raw_ascii", 1'b1, raw_ascii_o)
      `CHK("buf_base", 16'h1000, buf_base_o)
      `CHK("buf_last", 16'h103f, buf_last_o)
      wr(8'h14, 16'hffc1);
      req(16'h7355, 16'h70e5);
      `CHK("buf_base_kept", 16'h1000, buf_base_o)
      // A standard request while the staged protocol is raw gets no answer.
      req(16'h0055, 16'h0055);
      wr(8'h08, 16'h0020);
      req(16'h0055, 16'h00aa);
      `CHK("xon_off_mode", 1'b0, xon_en_o)
      `CHK("rts_off_mode", 1'b0, rts_en_o)
      // A raw request while the staged protocol is not raw gets no answer.
      req(16'h7155, 16'h7155);
      `CHK("xon_refused", 1'b0, xon_en_o)
      wr(8'h90, 16'h3a30);
      req(16'h0055, 16'h00e4);
      `CHK("p2_seconds_kept", 7'h05, p2_tmo_s_o)
      wr(8'h90, 16'h3030);
      wr(8'h08, 16'h0080);
      req(16'h0055, 16'h00aa);
      `CHK("proto_sel_8", 4'h8, proto_sel_o)
      `CHK("char_35_off", 1'b0, char_tmo_35_o)
      `CHK("p1_seconds_30", 7'h1e, p1_tmo_s_o)
      wr(8'h08, 16'h00e0);
      req(16'h0055, 16'h00aa);
      `CHK("proto_sel_e", 4'he, proto_sel_o)
      give_verdict();
   end

   initial
   begin
      repeat (3000) @(posedge clk_i);
      miscompares++;
      give_verdict();
   end
endmodule : testbench
